// ===== rtl/lbs_pkg.sv
// constants, types and helpers of the lcd bias sequencer with led backlight dimming
//
// Function
// [RULE1] a config field picks led boost frequency: 400k, 600k, 800k or 1 MHz
// [RULE2] a string with zero feedback current is marked open and its sink disabled
// [RULE3] an open string stays off until power-on reset or an enable toggle
// [RULE4] backlight enable is ignored until the gate-shaping delay has completed
// [RULE5] enable held high starts the led driver at the end of shaping delay
// [RULE6] a dimming input that never goes high keeps the led boost off
// [RULE7] on enable all six strings are checked once; unused ones are dropped
// [RULE8] one config bit selects direct or phase-shift dimming
// [RULE9] direct dimming switches all active sinks together with the dimming input
// [RULE10] phase-shift output frequency comes from a field, 15 to 22 kHz
// [RULE11] phase-shift reproduces input duty on each string, offset 360 deg over n
// [RULE12] logic regulator ramp starts first delay after supply exceeds lockout level
// [RULE13] system reset held low, released reset interval after logic regulator done
// [RULE14] source supply ramp begins second delay after system reset goes high
// [RULE15] negative gate ramp begins third delay after source supply ramp begins
// [RULE16] positive gate ramp begins as soon as negative gate ramp is done
// [RULE17] shaped gate held low until fourth delay after positive gate done
// [RULE18] panel discharge released sixth delay after supply exceeds detect level
// [RULE19] led driver runs only with source supply done and enable high
// [RULE20] supply below lockout disables logic, source and both gate supplies
// [RULE21] reset and discharge go low below their own selected threshold
// [RULE22] led driver off whenever enable is low or supply below lockout
// [RULE23] fourth delay programmable 0 to 35 ms
// [RULE24] system reset, once high, stays latched until power-down
// [RULE25] reset interval 0 to 15 ms; a bit picks its power-down threshold
// [RULE26] all delays count one timebase and restart from zero on reset
package lbs_pkg;

  // ---------------------------------------------------------------
  // clock and timebase
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int TICK_MS = 1; // delay resolution in ms
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int DLY_MAX_MS = 35;
  localparam int RST_MAX_MS = 15;
  localparam int PHASE_DIM_FREQ_SEL_MIN_HZ = 15_000;
  localparam int PHASE_DIM_FREQ_SEL_STEP_HZ = 1_000;
  localparam int NUM_STRINGS = 6;

  // ---------------------------------------------------------------
  // register map (byte offsets) and field positions
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CONFIG = 8'h00;
  localparam logic [7:0] REG_DELAY_A = 8'h04;
  localparam logic [7:0] REG_DELAY_B = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam int CFG_DIM_MODE = 0;
  localparam int CFG_RST_THR = 1;
  localparam int CFG_XAO_THR = 2;
  localparam int CFG_FSW_LSB = 4;
  localparam int CFG_PHASE_DIM_FREQ_SEL_LSB = 8;
  localparam int DLYA_D1_LSB = 0;
  localparam int DLYA_D2_LSB = 8;
  localparam int DLYA_D3_LSB = 16;
  localparam int DLYA_D4_LSB = 24;
  localparam int DLYB_D6_LSB = 0;
  localparam int DLYB_RST_LSB = 8;
  localparam logic [31:0] CONFIG_RST = 32'h0000_0000;
  localparam logic [31:0] DELAY_A_RST = 32'h0101_0101;
  localparam logic [31:0] DELAY_B_RST = 32'h0000_0101;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic uvlo_ok;         // supply above lockout level
    logic det_ok;          // supply above discharge detect level
    logic vcc_done;        // logic regulator ramp done
    logic avdd_done;       // source supply ramp done
    logic vgl_done;        // negative gate ramp done
    logic vgh_done;        // positive gate ramp done
    logic bl_en;           // backlight enable
    logic pwm;             // dimming input
    logic flicker_control_in;             // flicker control input
    logic [5:0] fb;        // string feedback current present
  } lbs_pins_t;

  typedef struct packed {
    logic vcc;
    logic avdd;
    logic vgl;
    logic vgh;
  } lbs_supply_en_t;

  // clamp a 6-bit delay field to the longest delay
  function automatic logic [5:0] lbs_dly_clamp(input logic [5:0] f);
    return (f > 6'(DLY_MAX_MS)) ? 6'(DLY_MAX_MS) : f;
  endfunction

  // phase-shift output period in clock cycles per frequency step
  function automatic logic [11:0] lbs_dim_period(input logic [2:0] sel);
    case (sel)
      3'h0: return 12'(CLK_HZ / (PHASE_DIM_FREQ_SEL_MIN_HZ + 0 * PHASE_DIM_FREQ_SEL_STEP_HZ));
      3'h1: return 12'(CLK_HZ / (PHASE_DIM_FREQ_SEL_MIN_HZ + 1 * PHASE_DIM_FREQ_SEL_STEP_HZ));
      3'h2: return 12'(CLK_HZ / (PHASE_DIM_FREQ_SEL_MIN_HZ + 2 * PHASE_DIM_FREQ_SEL_STEP_HZ));
      3'h3: return 12'(CLK_HZ / (PHASE_DIM_FREQ_SEL_MIN_HZ + 3 * PHASE_DIM_FREQ_SEL_STEP_HZ));
      3'h4: return 12'(CLK_HZ / (PHASE_DIM_FREQ_SEL_MIN_HZ + 4 * PHASE_DIM_FREQ_SEL_STEP_HZ));
      3'h5: return 12'(CLK_HZ / (PHASE_DIM_FREQ_SEL_MIN_HZ + 5 * PHASE_DIM_FREQ_SEL_STEP_HZ));
      3'h6: return 12'(CLK_HZ / (PHASE_DIM_FREQ_SEL_MIN_HZ + 6 * PHASE_DIM_FREQ_SEL_STEP_HZ));
      default: return 12'(CLK_HZ / (PHASE_DIM_FREQ_SEL_MIN_HZ + 7 * PHASE_DIM_FREQ_SEL_STEP_HZ));
    endcase
  endfunction

  // phase step in 1/256 of a period for n active strings
  function automatic logic [7:0] lbs_phase_step(input logic [2:0] n);
    case (n)
      3'h2: return 8'h80;
      3'h3: return 8'h55;
      3'h4: return 8'h40;
      3'h5: return 8'h33;
      3'h6: return 8'h2A;
      default: return 8'h00;
    endcase
  endfunction

endpackage

// ===== rtl/lbs_sequencer.sv
// power sequencer, reset and discharge timing, and led backlight dimming control
`timescale 1ns/100ps
module lbs_sequencer #(
  parameter int TICK_CYCLES = lbs_pkg::TICK_CYCLES,
  parameter int PWM_CNT_W = 20
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire lbs_pkg::lbs_pins_t pins_in,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output lbs_pkg::lbs_supply_en_t supply_en,
  output logic shaped_gate_output,
  output logic sys_reset_n_o,
  output logic sys_reset_n_oe,
  output logic panel_discharge_out_n_o,
  output logic panel_discharge_out_n_oe,
  output logic led_boost_en,
  output logic [1:0] led_boost_freq_sel,
  output logic [5:0] sink_gate
);
  import lbs_pkg::*;

  // ---------------------------------------------------------------
  // parameter checks
  // ---------------------------------------------------------------
  if (TICK_CYCLES < 2) begin : g_chk_tick
    $error("TICK_CYCLES must be at least 2");
  end
  if (PWM_CNT_W < 9) begin : g_chk_pwm
    $error("PWM_CNT_W must be at least 9");
  end

  localparam int TW = $clog2(TICK_CYCLES);

  typedef enum logic [3:0] {
    S_OFF, S_DLY1, S_VCC_RAMP, S_RST, S_DLY2, S_DLY3, S_VGL_RAMP, S_VGH_RAMP, S_SHAPING_DELAY_FIELD, S_RUN
  } lbs_seq_t;
  typedef enum logic [1:0] {L_OFF, L_CHECK, L_RUN} lbs_led_t;

  lbs_pins_t sync1_q, pin_q;
  logic [31:0] cfg_q, dly_a_q, dly_b_q;
  lbs_seq_t seq_q, seq_d;
  lbs_led_t led_q, led_d;
  logic [TW-1:0] cyc_q, xcyc_q;
  logic [5:0] ms_q, xms_q, target;
  logic elapsed, rst_rel_q, xao_rel_q, rst_thr, xao_thr;
  logic en_d_q, en_fall, led_req, checked_q, pwm_seen_q, pwm_d_q;
  logic [5:0] active_q;
  logic [PWM_CNT_W-1:0] hi_cnt_q, per_cnt_q, div_den_q;
  logic [PWM_CNT_W:0] div_rem_q, div_r2;
  logic [7:0] div_quo_q;
  logic [3:0] div_cnt_q;
  logic [8:0] duty_q;
  logic [11:0] ph_cnt_q, period;
  logic [12:0] acc_q, acc_n;
  logic [7:0] ph8_q, step;
  logic [2:0] n_act;
  logic [5:0] gate_d;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // two stages; only the second stage is read by logic
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sync1_q <= '0;
      pin_q <= '0;
    end else begin
      sync1_q <= pins_in;
      pin_q <= sync1_q;
    end
  end

  // ---------------------------------------------------------------
  // register port
  // ---------------------------------------------------------------
  // configuration writes
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cfg_q <= CONFIG_RST;
      dly_a_q <= DELAY_A_RST;
      dly_b_q <= DELAY_B_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        REG_CONFIG: cfg_q <= reg_wdata & 32'h0000_0737;
        REG_DELAY_A: dly_a_q <= reg_wdata & 32'h3F3F_3F3F;
        REG_DELAY_B: dly_b_q <= reg_wdata & 32'h0000_0F3F;
        default: ;
      endcase
    end
  end

  // read data one cycle after the strobe, zero otherwise and when unmapped
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_CONFIG: reg_rdata <= cfg_q;
        REG_DELAY_A: reg_rdata <= dly_a_q;
        REG_DELAY_B: reg_rdata <= dly_b_q;
        REG_STATUS: reg_rdata <= {10'h000, sink_gate, 2'h0, active_q, 3'h0, led_boost_en,
                                  led_q == L_RUN, xao_rel_q, rst_rel_q, seq_q == S_RUN};
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // ---------------------------------------------------------------
  // bias start-up sequencer
  // ---------------------------------------------------------------
  // delay target of the current state
  always_comb begin
    case (seq_q)
      S_DLY1: target = lbs_dly_clamp(dly_a_q[DLYA_D1_LSB +: 6]); // RULE12
      S_RST: target = {2'b00, dly_b_q[DLYB_RST_LSB +: 4]}; // RULE25
      S_DLY2: target = lbs_dly_clamp(dly_a_q[DLYA_D2_LSB +: 6]); // RULE14
      S_DLY3: target = lbs_dly_clamp(dly_a_q[DLYA_D3_LSB +: 6]); // RULE15
      S_SHAPING_DELAY_FIELD: target = lbs_dly_clamp(dly_a_q[DLYA_D4_LSB +: 6]); // RULE23
      default: target = 6'h00;
    endcase
    elapsed = (ms_q >= target);
  end

  // next state; lockout drops everything back to off
  always_comb begin
    seq_d = seq_q;
    case (seq_q)
      S_OFF: if (pin_q.uvlo_ok) seq_d = S_DLY1;
      S_DLY1: if (elapsed) seq_d = S_VCC_RAMP; // RULE12
      S_VCC_RAMP: if (pin_q.vcc_done) seq_d = S_RST;
      S_RST: if (elapsed) seq_d = S_DLY2; // RULE13
      S_DLY2: if (elapsed) seq_d = S_DLY3; // RULE14
      S_DLY3: if (elapsed) seq_d = S_VGL_RAMP; // RULE15
      S_VGL_RAMP: if (pin_q.vgl_done) seq_d = S_VGH_RAMP; // RULE16
      S_VGH_RAMP: if (pin_q.vgh_done) seq_d = S_SHAPING_DELAY_FIELD;
      S_SHAPING_DELAY_FIELD: if (elapsed) seq_d = S_RUN; // RULE17
      S_RUN: seq_d = S_RUN;
      default: seq_d = S_OFF;
    endcase
    if (!pin_q.uvlo_ok) seq_d = S_OFF; // RULE20
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) seq_q <= S_OFF;
    else seq_q <= seq_d;
  end

  // ms timebase, restarted on reset and on every state change
  always_ff @(posedge core_clk) begin
    if (!rst_n || seq_d != seq_q) begin // RULE26
      cyc_q <= '0;
      ms_q <= '0;
    end else if (cyc_q == TW'(TICK_CYCLES - 1)) begin
      cyc_q <= '0;
      if (ms_q != 6'h3F) ms_q <= ms_q + 6'h01;
    end else begin
      cyc_q <= cyc_q + TW'(1);
    end
  end

  // supply enables from the next state so they track it exactly
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      supply_en <= '0;
    end else begin
      supply_en.vcc <= seq_d >= S_VCC_RAMP; // RULE12 RULE20
      supply_en.avdd <= seq_d >= S_DLY3; // RULE14 RULE20
      supply_en.vgl <= seq_d >= S_VGL_RAMP; // RULE15 RULE20
      supply_en.vgh <= seq_d >= S_VGH_RAMP; // RULE16 RULE20
    end
  end

  // gate shaping: low until start-up done, then follows flicker control
  always_ff @(posedge core_clk) begin
    if (!rst_n) shaped_gate_output <= 1'b0;
    else shaped_gate_output <= (seq_q == S_RUN) && pin_q.flicker_control_in; // RULE17
  end

  // ---------------------------------------------------------------
  // system reset and panel discharge outputs
  // ---------------------------------------------------------------
  assign rst_thr = cfg_q[CFG_RST_THR] ? pin_q.det_ok : pin_q.uvlo_ok;
  assign xao_thr = cfg_q[CFG_XAO_THR] ? pin_q.det_ok : pin_q.uvlo_ok;

  // reset release latches; only its own threshold takes it low again
  always_ff @(posedge core_clk) begin
    if (!rst_n) rst_rel_q <= 1'b0;
    else if (!rst_thr) rst_rel_q <= 1'b0; // RULE21 RULE25
    else if (seq_q == S_RST && elapsed) rst_rel_q <= 1'b1; // RULE13 RULE24
  end

  // discharge delay counter runs while supply is above detect level
  always_ff @(posedge core_clk) begin
    if (!rst_n || !pin_q.det_ok) begin // RULE26
      xcyc_q <= '0;
      xms_q <= '0;
    end else if (xcyc_q == TW'(TICK_CYCLES - 1)) begin
      xcyc_q <= '0;
      if (xms_q != 6'h3F) xms_q <= xms_q + 6'h01;
    end else begin
      xcyc_q <= xcyc_q + TW'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) xao_rel_q <= 1'b0;
    else if (!xao_thr) xao_rel_q <= 1'b0; // RULE21
    else if (pin_q.det_ok && xms_q >= lbs_dly_clamp(dly_b_q[DLYB_D6_LSB +: 6]))
      xao_rel_q <= 1'b1; // RULE18
  end

  // open-drain drivers: enable pulls the pin low
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sys_reset_n_o <= 1'b0;
      sys_reset_n_oe <= 1'b1;
      panel_discharge_out_n_o <= 1'b0;
      panel_discharge_out_n_oe <= 1'b1;
    end else begin
      sys_reset_n_o <= 1'b0;
      sys_reset_n_oe <= !rst_rel_q; // RULE13
      panel_discharge_out_n_o <= 1'b0;
      panel_discharge_out_n_oe <= !xao_rel_q; // RULE18
    end
  end

  // ---------------------------------------------------------------
  // led driver enable, string check and open detection
  // ---------------------------------------------------------------
  assign led_req = (seq_q == S_RUN) && pin_q.bl_en && pin_q.avdd_done
                   && pin_q.uvlo_ok; // RULE4 RULE5 RULE19 RULE22
  assign en_fall = en_d_q && !pin_q.bl_en;

  always_comb begin
    led_d = led_q;
    case (led_q)
      L_OFF: if (led_req) led_d = L_CHECK;
      L_CHECK: led_d = L_RUN;
      L_RUN: led_d = L_RUN;
      default: led_d = L_OFF;
    endcase
    if (!led_req) led_d = L_OFF; // RULE22
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      led_q <= L_OFF;
      en_d_q <= 1'b0;
    end else begin
      led_q <= led_d;
      en_d_q <= pin_q.bl_en;
    end
  end

  // active string mask: restored by reset or an enable toggle only
  always_ff @(posedge core_clk) begin
    if (!rst_n || en_fall) begin // RULE3
      active_q <= '1;
      checked_q <= 1'b0;
    end else if (led_q == L_CHECK && !checked_q) begin
      active_q <= active_q & pin_q.fb; // RULE7
      checked_q <= 1'b1;
    end else if (led_q == L_RUN) begin
      active_q <= active_q & ~(sink_gate & ~pin_q.fb); // RULE2
    end
  end

  // the boost waits for a first high dimming level
  always_ff @(posedge core_clk) begin
    if (!rst_n || led_q != L_RUN) pwm_seen_q <= 1'b0;
    else if (pin_q.pwm) pwm_seen_q <= 1'b1; // RULE6
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      led_boost_en <= 1'b0;
      led_boost_freq_sel <= 2'b00;
    end else begin
      led_boost_en <= (led_q == L_RUN) && pwm_seen_q && pin_q.bl_en
                      && pin_q.uvlo_ok; // RULE6 RULE22
      led_boost_freq_sel <= cfg_q[CFG_FSW_LSB +: 2]; // RULE1
    end
  end

  // ---------------------------------------------------------------
  // input duty measurement for phase-shift dimming
  // ---------------------------------------------------------------
  // high time and period of the dimming input, saturating
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pwm_d_q <= 1'b0;
      hi_cnt_q <= '0;
      per_cnt_q <= '0;
    end else begin
      pwm_d_q <= pin_q.pwm;
      if (pin_q.pwm && !pwm_d_q) begin
        hi_cnt_q <= PWM_CNT_W'(1);
        per_cnt_q <= PWM_CNT_W'(1);
      end else if (per_cnt_q != '1) begin
        per_cnt_q <= per_cnt_q + PWM_CNT_W'(1);
        if (pin_q.pwm) hi_cnt_q <= hi_cnt_q + PWM_CNT_W'(1);
      end
    end
  end

  assign div_r2 = {div_rem_q[PWM_CNT_W-1:0], 1'b0};

  // duty = high * 256 / period by restoring division, one bit per cycle
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      div_rem_q <= '0;
      div_den_q <= '0;
      div_quo_q <= '0;
      div_cnt_q <= '0;
      duty_q <= '0;
    end else if (pin_q.pwm && !pwm_d_q && per_cnt_q != '1) begin
      div_den_q <= per_cnt_q;
      div_rem_q <= {1'b0, hi_cnt_q};
      div_cnt_q <= (hi_cnt_q >= per_cnt_q) ? 4'h0 : 4'h8;
      if (hi_cnt_q >= per_cnt_q) duty_q <= 9'h100;
    end else if (div_cnt_q != 4'h0) begin
      div_cnt_q <= div_cnt_q - 4'h1;
      if (div_r2 >= {1'b0, div_den_q}) begin
        div_rem_q <= div_r2 - {1'b0, div_den_q};
        div_quo_q <= {div_quo_q[6:0], 1'b1};
      end else begin
        div_rem_q <= div_r2;
        div_quo_q <= {div_quo_q[6:0], 1'b0};
      end
      if (div_cnt_q == 4'h1)
        duty_q <= {1'b0, div_quo_q[6:0], div_r2 >= {1'b0, div_den_q}};
    end else if (per_cnt_q == '1) begin
      duty_q <= pin_q.pwm ? 9'h100 : 9'h000; // steady input level
    end
  end

  // ---------------------------------------------------------------
  // phase-shift timebase
  // ---------------------------------------------------------------
  assign period = lbs_dim_period(cfg_q[CFG_PHASE_DIM_FREQ_SEL_LSB +: 3]); // RULE10
  assign acc_n = acc_q + 13'h0100;

  // ph8 is the position in 1/256 of the output period
  always_ff @(posedge core_clk) begin
    if (!rst_n || ph_cnt_q >= period - 12'h001) begin
      ph_cnt_q <= '0;
      acc_q <= '0;
      ph8_q <= '0;
    end else begin
      ph_cnt_q <= ph_cnt_q + 12'h001;
      if (acc_n >= {1'b0, period}) begin
        acc_q <= acc_n - {1'b0, period};
        ph8_q <= ph8_q + 8'h01;
      end else begin
        acc_q <= acc_n;
      end
    end
  end

  assign n_act = 3'($countones(active_q));
  assign step = lbs_phase_step(n_act);

  // ---------------------------------------------------------------
  // current sink gates
  // ---------------------------------------------------------------
  for (genvar i = 0; i < NUM_STRINGS; i++) begin : g_sink
    logic [2:0] rank;
    logic [7:0] pos;
    assign rank = 3'($countones(active_q & ((6'h01 << i) - 6'h01))); // active strings below
    assign pos = ph8_q + 8'(rank * step); // RULE11
    always_comb begin
      if (!cfg_q[CFG_DIM_MODE]) gate_d[i] = active_q[i] && pin_q.pwm; // RULE8 RULE9
      else gate_d[i] = active_q[i] && ({1'b0, pos} < duty_q); // RULE8 RULE11
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) sink_gate <= '0;
    else sink_gate <= (led_q == L_RUN && pin_q.bl_en) ? gate_d : 6'h00; // RULE19
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_vgl_done_seen;
    seq_q == S_VGL_RAMP && pin_q.vgl_done && pin_q.uvlo_ok;
  endsequence
  sequence s_vgh_on;
    seq_q == S_VGH_RAMP && supply_en.vgh;
  endsequence

  property p_vgh_follows;
    s_vgl_done_seen |=> s_vgh_on;
  endproperty
  a_vgh_follows: assert property (p_vgh_follows) else $error("gate high late"); // RULE16

  property p_lockout_off;
    !pin_q.uvlo_ok |=> supply_en == '0 ##1 !led_boost_en;
  endproperty
  a_lockout_off: assert property (p_lockout_off) else $error("supply on in lockout"); // RULE20

  property p_led_off_en_low;
    !pin_q.bl_en |=> !led_boost_en && sink_gate == 6'h00;
  endproperty
  a_led_off_en_low: assert property (p_led_off_en_low) else $error("led on enable low"); // RULE22

  property p_rst_latched;
    rst_rel_q && rst_thr |=> rst_rel_q;
  endproperty
  a_rst_latched: assert property (p_rst_latched) else $error("reset dropped"); // RULE24

  property p_rst_pin;
    rst_rel_q |=> !sys_reset_n_oe;
  endproperty
  a_rst_pin: assert property (p_rst_pin) else $error("reset pin wrong"); // RULE13

  property p_shape_low;
    seq_q != S_RUN |=> !shaped_gate_output;
  endproperty
  a_shape_low: assert property (p_shape_low) else $error("shaping early"); // RULE17

  property p_no_pwm_no_boost;
    !pwm_seen_q |=> !led_boost_en;
  endproperty
  a_no_pwm_no_boost: assert property (p_no_pwm_no_boost) else $error("boost without pwm"); // RULE6

  property p_open_stays;
    !en_fall |=> (active_q & ~$past(active_q)) == 6'h00;
  endproperty
  a_open_stays: assert property (p_open_stays) else $error("open string revived"); // RULE3

  property p_direct;
    !cfg_q[CFG_DIM_MODE] && led_q == L_RUN && pin_q.bl_en
      |=> sink_gate == ($past(active_q) & {6{$past(pin_q.pwm)}});
  endproperty
  a_direct: assert property (p_direct) else $error("direct dimming mismatch"); // RULE9

  property p_bias_first;
    seq_q != S_RUN |=> led_q == L_OFF;
  endproperty
  a_bias_first: assert property (p_bias_first) else $error("led before bias"); // RULE4

endmodule

// ===== sim/lbs_analog_model.sv
// behavioural regulators: ramp-done flags follow the supply enables
`timescale 1ns/100ps
module lbs_analog_model (
  input wire logic core_clk,
  input wire lbs_pkg::lbs_supply_en_t supply_en,
  output logic [3:0] ramp_done
);
  import lbs_pkg::*;
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  // a ramp takes three cycles; a disabled supply drops its flag next edge
  always_ff @(posedge core_clk) begin
    s1_q <= supply_en;
    s2_q <= s1_q;
    ramp_done <= supply_en & s2_q;
  end
endmodule

// ===== sim/lbs_sequencer_tb.sv
// testbench of the bias sequencer and backlight dimming control
`timescale 1ns/100ps
module lbs_sequencer_tb;
  import lbs_pkg::*;
  logic core_clk, rst_n, uvlo, det, bl, pwm, flicker_control_in, reg_wr, reg_rd, shaped, rst_oe, xao_oe, boost;
  logic [5:0] fb;
  logic [5:0] sink;
  logic [1:0] fsel;
  logic [3:0] done;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  lbs_supply_en_t sup;
  int n_mismatch, n_tests, n_hi, n_both;
  logic rst_o, xao_o;
  lbs_sequencer #(.TICK_CYCLES(4)) dut_u (.core_clk(core_clk), .rst_n(rst_n),
    .pins_in({uvlo, det, done, bl, pwm, flicker_control_in, fb}), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .supply_en(sup), .shaped_gate_output(shaped), .sys_reset_n_o(rst_o), .sys_reset_n_oe(rst_oe),
    .panel_discharge_out_n_o(xao_o), .panel_discharge_out_n_oe(xao_oe), .led_boost_en(boost),
    .led_boost_freq_sel(fsel), .sink_gate(sink));
  lbs_analog_model model_u (.core_clk(core_clk), .supply_en(sup), .ramp_done(done));
  // -------------------------------------------------------------
  // bus and compare tasks
  // -------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(nm, e, reg_rdata);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    tick(8000);
    n_mismatch++;
    final_report();
  end
  // -------------------------------------------------------------
  // test sequence
  // -------------------------------------------------------------
  initial begin
    {rst_n, uvlo, det, reg_wr, reg_rd, flicker_control_in, reg_addr, reg_wdata} = '0;
    {bl, pwm, fb} = {2'b11, 6'h1F};
    tick(3);
    rst_n <= 1'b1;
    chk("supply_en", 32'h0, 32'(sup));
    chk("reset_oe", 32'h1, 32'(rst_oe));
    chk("discharge_oe", 32'h1, 32'(xao_oe));
    rd(8'h04, 32'h0101_0101, "delay_a");
    rd(8'h08, 32'h0000_0101, "delay_b");
    rd(8'h10, 32'h0, "unmapped");
    for (int f = 0; f < 4; f++) begin
      wr(8'h00, 32'(f) << 4);
      tick(2);
      chk("freq_sel", 32'(f), 32'(fsel));
    end
    wr(8'h00, 32'hFFFF_FFFF);
    rd(8'h00, 32'h0000_0737, "config_mask");
    wr(8'h00, 32'h0);
    uvlo <= 1'b1;
    det <= 1'b1;
    for (int i = 0; i < 300 && !sup.vcc; i++) tick(1);
    chk("vcc_on", 32'h1, 32'(sup.vcc));
    chk("reset_oe_at_vcc", 32'h1, 32'(rst_oe));
    for (int i = 0; i < 300 && rst_oe; i++) tick(1);
    chk("reset_released", 32'h0, 32'(rst_oe));
    chk("avdd_at_reset", 32'h0, 32'(sup.avdd));
    chk("discharge_rel", 32'h0, 32'(xao_oe));
    for (int i = 0; i < 300 && !sup.avdd; i++) tick(1);
    chk("avdd_on", 32'h1, 32'(sup.avdd));
    chk("vgl_at_avdd", 32'h0, 32'(sup.vgl));
    for (int i = 0; i < 300 && !sup.vgh; i++) tick(1);
    chk("vgh_on", 32'h1, 32'(sup.vgh));
    chk("shaped_early", 32'h0, 32'(shaped));
    chk("boost_early", 32'h0, 32'(boost));
    flicker_control_in <= 1'b1;
    tick(30);
    chk("shaped_run", 32'h1, 32'(shaped));
    chk("sinks_start", 32'h1F, 32'(sink));
    chk("boost_run", 32'h1, 32'(boost));
    rd(8'h0C, 32'h001F_1F1F, "status");
    fb <= 6'h1E;
    tick(8);
    chk("sinks_open", 32'h1E, 32'(sink));
    {bl, pwm} <= 2'b00;
    tick(6);
    chk("boost_bl_low", 32'h0, 32'(boost));
    {fb, bl} <= {6'h3F, 1'b1};
    tick(40);
    chk("boost_no_pwm", 32'h0, 32'(boost));
    pwm <= 1'b1;
    tick(8);
    chk("sinks_toggle", 32'h3F, 32'(sink));
    pwm <= 1'b0;
    tick(5);
    chk("sinks_pwm_low", 32'h0, 32'(sink));
    // phase-shift: 50% input at a foreign rate, then one output period observed
    wr(8'h00, 32'h1);
    repeat (8) begin
      pwm <= 1'b1;
      tick(20);
      pwm <= 1'b0;
      tick(20);
    end
    repeat (1333) begin
      tick(1);
      n_hi += sink[0];
      n_both += sink[0] & sink[3];
    end
    chk("phase_duty", 32'h1, 32'(n_hi > 600 && n_hi < 733));
    chk("phase_offset", 32'h1, 32'(n_both < 40));
    {uvlo, det} <= 2'b00;
    tick(6);
    chk("supply_off", 32'h0, 32'(sup));
    chk("boost_off", 32'h0, 32'(boost));
    chk("reset_low", 32'h1, 32'(rst_oe));
    chk("discharge_low", 32'h1, 32'(xao_oe));
    chk("od_levels", 32'h0, 32'({rst_o, xao_o}));
    final_report();
  end
endmodule
